// File: rtl/roc_pkg.sv
// Constants, types and register map of the restrained overcurrent stage.
// What this block does
// - Sample block input at each program cycle start.
// - Pick-up while unblocked raises start, starts timing.
// - Pick-up while blocked raises blocked, nothing more.
// - Block during start drops start, releases timing.
// - Blocking gives display note and block event.
// - Six ON/OFF event codes from output changes.
// - Selection passes ON, OFF or both events.
// - Events carry time stamp and process data.
// - Fault record memory keeps last twelve entries.
// - Records are written for ON transitions only.
// - Record holds stamp, event, currents, voltage, group.
// - Condition code: normal, started, tripped, blocked.
// - Behaviour code visible only when enabled.
// - Expected operate time, inverse mode tracks current.
// - Remaining time counts down in 5 ms steps.
// - Voltage status invalid when voltage unavailable.
// - Pick-up level now in 0.01 per-unit.
// - Positive-sequence voltage now in 0.01 percent.
// - Current to pick-up ratio in 0.01 steps.
// - Pick-up drops below 97 percent of level.
// - Rising knees scale pick-up; equal or falling knees step it at UX1.
// - Stamps in 1 ms, instant events share stamp.
package roc_pkg;
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned CYCLE_US = 5000;
	localparam int unsigned CYCLE_CLKS = CLK_HZ / 1_000_000 * CYCLE_US;
	localparam int unsigned STAMP_US = 1000;
	localparam int unsigned STAMP_CLKS = CLK_HZ / 1_000_000 * STAMP_US;
	localparam int unsigned BLOCK_LEAD_MS = 5;
	localparam int unsigned REC_DEPTH = 12;
	localparam int unsigned PRE_TRIG_MS = 20;
	localparam int unsigned PRE_FAULT_MS = 200;
	localparam int unsigned PRE_TRIG_CYC = PRE_TRIG_MS * 1000 / CYCLE_US;
	localparam int unsigned PRE_FAULT_CYC = PRE_FAULT_MS * 1000 / CYCLE_US;
	localparam int unsigned DROP_PCT = 97;
	localparam int unsigned MAX_STEPS = 360000;
	localparam logic [1:0] COND_NORMAL = 2'h0;
	localparam logic [1:0] COND_START = 2'h1;
	localparam logic [1:0] COND_TRIP = 2'h2;
	localparam logic [1:0] COND_BLOCK = 2'h3;
	localparam logic [2:0] LN_ON = 3'h1;
	localparam logic [2:0] LN_BLOCKED = 3'h2;
	localparam logic [2:0] LN_TEST_BLOCKED = 3'h4;
	localparam logic [2:0] LN_OFF = 3'h5;
	localparam logic [2:0] EV_BLOCK_ON = 3'h4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_IV1 = 8'h04;
	localparam logic [7:0] A_IV2 = 8'h08;
	localparam logic [7:0] A_UX1 = 8'h0c;
	localparam logic [7:0] A_UX2 = 8'h10;
	localparam logic [7:0] A_DELAY = 8'h14;
	localparam logic [7:0] A_STATUS = 8'h18;
	localparam logic [7:0] A_EXPECT = 8'h1c;
	localparam logic [7:0] A_REMAIN = 8'h20;
	localparam logic [7:0] A_PICKUP = 8'h24;
	localparam logic [7:0] A_VOLT = 8'h28;
	localparam logic [7:0] A_RATIO = 8'h2c;
	localparam logic [7:0] A_REC_SEL = 8'h30;
	localparam logic [7:0] A_REC_CNT = 8'h34;
	localparam logic [7:0] A_REC_BASE = 8'h38;
	localparam logic [7:0] A_REC_LAST = 8'h5c;
	localparam logic [31:0] CTRL_RST = 32'h0000_0013;
	localparam logic [15:0] IV1_RST = 16'h0014;
	localparam logic [15:0] IV2_RST = 16'h0078;
	localparam logic [15:0] UX1_RST = 16'h07d0;
	localparam logic [15:0] UX2_RST = 16'h2710;
	localparam logic [18:0] DELAY_RST = 19'h0_0014;
	typedef enum logic [1:0] {ST_NORMAL, ST_START, ST_TRIP, ST_BLOCK} roc_state_t;
	typedef struct packed {
		logic [15:0] il1;
		logic [15:0] il2;
		logic [15:0] il3;
		logic [15:0] u1;
		logic u1_ok;
	} roc_meas_t;
	typedef struct packed {
		logic valid;
		logic [2:0] code;
		logic [31:0] stamp;
		logic [15:0] u1;
		logic [15:0] cur;
		logic [2:0] ftype;
	} roc_event_t;
	typedef struct packed {
		logic [31:0] stamp;
		logic [2:0] code;
		logic [2:0] ftype;
		logic [15:0] pre_trig;
		logic [15:0] cur;
		logic [15:0] u1;
		logic [15:0] pickup;
		logic [15:0] pre_fault;
		logic [18:0] remain;
		logic [2:0] group;
	} roc_rec_t;
endpackage

// File: rtl/roc_stage.sv
// Restrained overcurrent stage: blocking, timing, events, fault records.
`timescale 1ns/1ps
`default_nettype none
module roc_stage import roc_pkg::*; #(
	parameter int unsigned CYC_CLKS = CYCLE_CLKS,
	parameter int unsigned MS_CLKS = STAMP_CLKS,
	parameter int unsigned DEPTH = REC_DEPTH
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic block_in,
	input wire roc_meas_t meas,
	output logic start_out,
	output logic trip_out,
	output logic blocked_out,
	output logic display_note,
	output roc_event_t event_out
);
	localparam int CW = $clog2(CYC_CLKS + 1);
	localparam int MW = $clog2(MS_CLKS + 1);
	localparam int PW = $clog2(DEPTH);

	initial begin
		if (CYC_CLKS < 2 || MS_CLKS < 2 || DEPTH < 2 || PRE_FAULT_CYC < PRE_TRIG_CYC)
			$error("roc_stage: unsupported parameter values");
	end

	function automatic logic [31:0] sat_div(input logic [31:0] num, input logic [31:0] den);
		logic [31:0] q;
		q = (den == 32'h0000_0000) ? 32'hffff_ffff : num / den;
		return q;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) m[i*8 +: 8] = d[i*8 +: 8];
		end
		return m;
	endfunction

	// Bus-side state.
	logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
	logic [7:0] aw_addr_r, aw_addr_nxt, rd_addr;
	logic [31:0] w_data_r, w_data_nxt;
	logic [3:0] w_be_r, w_be_nxt;
	logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [31:0] ctrl_r, ctrl_nxt;
	logic [15:0] iv1_r, iv1_nxt, iv2_r, iv2_nxt, ux1_r, ux1_nxt, ux2_r, ux2_nxt;
	logic [18:0] delay_r, delay_nxt;
	logic [PW-1:0] sel_r, sel_nxt;

	// Stage state.
	logic [CW-1:0] cyc_r, cyc_nxt;
	logic [MW-1:0] ms_r, ms_nxt;
	logic [31:0] stamp_r, stamp_nxt;
	roc_state_t st_r, st_nxt;
	logic pick_r, pick_nxt, blk_r, blk_nxt;
	logic [18:0] rem_r, rem_nxt, exp_r, exp_nxt;
	logic [15:0] lvl_r, lvl_nxt, ratio_r, ratio_nxt;
	logic [5:0] pend_r, pend_nxt;
	roc_rec_t snap_r, snap_nxt;
	roc_event_t ev_r, ev_nxt;
	logic note_r, note_nxt;
	logic [15:0] hist_r [PRE_FAULT_CYC];
	logic [15:0] hist_nxt [PRE_FAULT_CYC];
	roc_rec_t mem_r [DEPTH];
	logic [PW-1:0] wptr_r, wptr_nxt, rd_idx;
	logic [PW:0] cnt_r, cnt_nxt;
	logic rec_we;
	roc_rec_t rec_d;

	logic tick, over, hold, blk_now, start_o, trip_o, blk_o, so, to, bo;
	logic [15:0] imax;
	logic [2:0] ftype, code;
	logic [31:0] ratio32, span;
	logic wr_go, rd_go;

	always_comb begin
		aw_held_nxt = aw_held_r;
		aw_addr_nxt = aw_addr_r;
		w_held_nxt = w_held_r;
		w_data_nxt = w_data_r;
		w_be_nxt = w_be_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		ctrl_nxt = ctrl_r;
		iv1_nxt = iv1_r;
		iv2_nxt = iv2_r;
		ux1_nxt = ux1_r;
		ux2_nxt = ux2_r;
		delay_nxt = delay_r;
		sel_nxt = sel_r;
		rd_addr = s_axi_araddr;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_nxt = 1'b1;
			aw_addr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_nxt = 1'b1;
			w_data_nxt = s_axi_wdata;
			w_be_nxt = s_axi_wstrb;
		end
		wr_go = aw_held_r && w_held_r && !bvalid_r;
		if (wr_go) begin
			aw_held_nxt = 1'b0;
			w_held_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = RESP_OKAY;
			unique case ({aw_addr_r[7:2], 2'b00})
				A_CTRL: ctrl_nxt = merge(ctrl_r, w_data_r, w_be_r);
				A_IV1: iv1_nxt = 16'(merge({16'h0000, iv1_r}, w_data_r, w_be_r));
				A_IV2: iv2_nxt = 16'(merge({16'h0000, iv2_r}, w_data_r, w_be_r));
				A_UX1: ux1_nxt = 16'(merge({16'h0000, ux1_r}, w_data_r, w_be_r));
				A_UX2: ux2_nxt = 16'(merge({16'h0000, ux2_r}, w_data_r, w_be_r));
				A_DELAY: delay_nxt = 19'(merge({13'h0000, delay_r}, w_data_r, w_be_r));
				A_REC_SEL: sel_nxt = PW'(merge({{(32-PW){1'b0}}, sel_r}, w_data_r, w_be_r));
				default: bresp_nxt = RESP_SLVERR;
			endcase
		end
		if (bvalid_r && s_axi_bready) bvalid_nxt = 1'b0;
		rd_go = s_axi_arvalid && s_axi_arready;
		if (rd_go) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			rdata_nxt = 32'h0000_0000;
			unique case ({rd_addr[7:2], 2'b00})
				A_CTRL: rdata_nxt = ctrl_r;
				A_IV1: rdata_nxt = {16'h0000, iv1_r};
				A_IV2: rdata_nxt = {16'h0000, iv2_r};
				A_UX1: rdata_nxt = {16'h0000, ux1_r};
				A_UX2: rdata_nxt = {16'h0000, ux2_r};
				A_DELAY: rdata_nxt = {13'h0000, delay_r};
				// Condition, behaviour (zero when hidden) and voltage status.
				A_STATUS: rdata_nxt = {23'h00_0000, meas.u1_ok, 1'b0,
					ctrl_r[3] ? ctrl_r[6:4] : 3'h0, 2'b00,
					blk_o ? COND_BLOCK : trip_o ? COND_TRIP : start_o ? COND_START : COND_NORMAL};
				A_EXPECT: rdata_nxt = {13'h0000, exp_r};
				A_REMAIN: rdata_nxt = {13'h0000, rem_r};
				A_PICKUP: rdata_nxt = {16'h0000, lvl_r};
				A_VOLT: rdata_nxt = {16'h0000, meas.u1};
				A_RATIO: rdata_nxt = {16'h0000, ratio_r};
				A_REC_SEL: rdata_nxt = 32'(sel_r);
				A_REC_CNT: rdata_nxt = 32'(cnt_r);
				A_REC_BASE: rdata_nxt = mem_r[rd_idx].stamp;
				A_REC_BASE + 8'h04: rdata_nxt = 32'(mem_r[rd_idx].code);
				A_REC_BASE + 8'h08: rdata_nxt = 32'(mem_r[rd_idx].ftype);
				A_REC_BASE + 8'h0c: rdata_nxt = 32'(mem_r[rd_idx].pre_trig);
				A_REC_BASE + 8'h10: rdata_nxt = 32'(mem_r[rd_idx].cur);
				A_REC_BASE + 8'h14: rdata_nxt = 32'(mem_r[rd_idx].u1);
				A_REC_BASE + 8'h18: rdata_nxt = 32'(mem_r[rd_idx].pickup);
				A_REC_BASE + 8'h1c: rdata_nxt = 32'(mem_r[rd_idx].pre_fault);
				A_REC_BASE + 8'h20: rdata_nxt = 32'(mem_r[rd_idx].remain);
				A_REC_LAST: rdata_nxt = 32'(mem_r[rd_idx].group);
				default: rresp_nxt = RESP_SLVERR;
			endcase
		end
		if (rvalid_r && s_axi_rready) rvalid_nxt = 1'b0;
	end

	// Entry sel_r counts back from the newest record.
	assign rd_idx = (wptr_r > sel_r) ? PW'(wptr_r - sel_r - 1'b1) : PW'(DEPTH + wptr_r - sel_r - 1);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_held_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_be_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h0000_0000;
			ctrl_r <= CTRL_RST;
			iv1_r <= IV1_RST;
			iv2_r <= IV2_RST;
			ux1_r <= UX1_RST;
			ux2_r <= UX2_RST;
			delay_r <= DELAY_RST;
			sel_r <= '0;
		end else begin
			aw_held_r <= aw_held_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_held_r <= w_held_nxt;
			w_data_r <= w_data_nxt;
			w_be_r <= w_be_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
			ctrl_r <= ctrl_nxt;
			iv1_r <= iv1_nxt;
			iv2_r <= iv2_nxt;
			ux1_r <= ux1_nxt;
			ux2_r <= ux2_nxt;
			delay_r <= delay_nxt;
			sel_r <= sel_nxt;
		end
	end

	assign s_axi_awready = !aw_held_r;
	assign s_axi_wready = !w_held_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;

	always_comb begin
		cyc_nxt = cyc_r + 1'b1;
		tick = 1'b0;
		if (cyc_r == CW'(CYC_CLKS - 1)) begin
			cyc_nxt = '0;
			tick = 1'b1;
		end
		ms_nxt = ms_r + 1'b1;
		stamp_nxt = stamp_r;
		if (ms_r == MW'(MS_CLKS - 1)) begin
			ms_nxt = '0;
			stamp_nxt = stamp_r + 1'b1;
		end
		imax = meas.il1;
		if (meas.il2 > imax) imax = meas.il2;
		if (meas.il3 > imax) imax = meas.il3;
		ftype = {meas.il3 >= lvl_r, meas.il2 >= lvl_r, meas.il1 >= lvl_r};
		// Pick-up level from voltage between the knees.
		span = 32'(ux2_r - ux1_r);
		if (!meas.u1_ok || meas.u1 <= ux1_r) lvl_nxt = iv1_r;
		else if (ux2_r <= ux1_r || meas.u1 >= ux2_r) lvl_nxt = iv2_r;
		else lvl_nxt = 16'(32'(iv1_r) + sat_div(32'(iv2_r - iv1_r) * 32'(meas.u1 - ux1_r), span));
		ratio32 = sat_div(32'(imax) * 32'd100, 32'(lvl_r));
		ratio_nxt = (ratio32 > 32'h0000_ffff) ? 16'hffff : ratio32[15:0];
		exp_nxt = delay_r;
		if (ctrl_r[2]) begin
			// Inverse time follows the present highest current.
			ratio32 = (ratio32 > 32'd100) ? sat_div(32'(delay_r) * 32'd100, ratio32 - 32'd100) : 32'(MAX_STEPS);
			exp_nxt = (ratio32 > 32'(MAX_STEPS)) ? 19'(MAX_STEPS) : ratio32[18:0];
		end
		over = imax >= lvl_r;
		hold = 32'(imax) * 32'd100 >= 32'(lvl_r) * 32'(DROP_PCT);
		pick_nxt = pick_r;
		blk_nxt = blk_r;
		st_nxt = st_r;
		rem_nxt = rem_r;
		snap_nxt = snap_r;
		hist_nxt = hist_r;
		blk_now = block_in || ctrl_r[6:4] == LN_BLOCKED || ctrl_r[6:4] == LN_TEST_BLOCKED;
		if (tick) begin
			blk_nxt = blk_now;
			pick_nxt = (over || (pick_r && hold)) && ctrl_r[6:4] != LN_OFF;
			hist_nxt[0] = imax;
			for (int i = 1; i < PRE_FAULT_CYC; i++) hist_nxt[i] = hist_r[i-1];
			unique case (st_r)
				ST_NORMAL: begin
					if (pick_nxt && !pick_r && blk_now) st_nxt = ST_BLOCK;
					else if (pick_nxt && !pick_r) begin
						st_nxt = (exp_r == '0) ? ST_TRIP : ST_START;
						rem_nxt = exp_r;
					end
				end
				ST_START: begin
					if (!pick_nxt || blk_now) begin
						st_nxt = (pick_nxt && blk_now) ? ST_BLOCK : ST_NORMAL;
						rem_nxt = '0;
					end else if (rem_r <= 19'h0_0001) begin
						st_nxt = ST_TRIP;
						rem_nxt = '0;
					end else begin
						rem_nxt = rem_r - 1'b1;
					end
				end
				ST_TRIP, ST_BLOCK: if (!pick_nxt) st_nxt = ST_NORMAL;
			endcase
			snap_nxt.stamp = stamp_r;
			snap_nxt.ftype = ftype;
			snap_nxt.pre_trig = hist_r[PRE_TRIG_CYC-1];
			snap_nxt.cur = imax;
			snap_nxt.u1 = meas.u1;
			snap_nxt.pickup = lvl_r;
			snap_nxt.pre_fault = hist_r[PRE_FAULT_CYC-1];
			snap_nxt.remain = rem_nxt;
			snap_nxt.group = ctrl_r[10:8];
		end
		so = st_nxt == ST_START || st_nxt == ST_TRIP;
		to = st_nxt == ST_TRIP;
		bo = st_nxt == ST_BLOCK;
		// One pending bit per event code; even codes are ON.
		pend_nxt = pend_r;
		code = 3'h0;
		for (int i = 5; i >= 0; i--) begin
			if (pend_r[i]) code = 3'(i);
		end
		ev_nxt = '0;
		note_nxt = 1'b0;
		rec_we = 1'b0;
		rec_d = snap_r;
		rec_d.code = code;
		if (pend_r != 6'h00) begin
			pend_nxt[code] = 1'b0;
			ev_nxt.valid = code[0] ? ctrl_r[1] : ctrl_r[0];
			ev_nxt.code = code;
			ev_nxt.stamp = snap_r.stamp;
			ev_nxt.u1 = snap_r.u1;
			ev_nxt.cur = snap_r.cur;
			ev_nxt.ftype = snap_r.ftype;
			rec_we = !code[0];
			note_nxt = code == EV_BLOCK_ON;
		end
		pend_nxt = pend_nxt | {blk_o & !bo, bo & !blk_o, trip_o & !to, to & !trip_o, start_o & !so, so & !start_o};
		wptr_nxt = wptr_r;
		cnt_nxt = cnt_r;
		if (rec_we) begin
			wptr_nxt = (wptr_r == PW'(DEPTH - 1)) ? '0 : wptr_r + 1'b1;
			if (cnt_r != (PW+1)'(DEPTH)) cnt_nxt = cnt_r + 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cyc_r <= '0;
			ms_r <= '0;
			stamp_r <= 32'h0000_0000;
			st_r <= ST_NORMAL;
			pick_r <= 1'b0;
			blk_r <= 1'b0;
			rem_r <= '0;
			exp_r <= '0;
			lvl_r <= IV1_RST;
			ratio_r <= 16'h0000;
			pend_r <= 6'h00;
			snap_r <= '0;
			ev_r <= '0;
			note_r <= 1'b0;
			wptr_r <= '0;
			cnt_r <= '0;
			start_o <= 1'b0;
			trip_o <= 1'b0;
			blk_o <= 1'b0;
			for (int i = 0; i < PRE_FAULT_CYC; i++) hist_r[i] <= 16'h0000;
		end else begin
			cyc_r <= cyc_nxt;
			ms_r <= ms_nxt;
			stamp_r <= stamp_nxt;
			st_r <= st_nxt;
			pick_r <= pick_nxt;
			blk_r <= blk_nxt;
			rem_r <= rem_nxt;
			exp_r <= exp_nxt;
			lvl_r <= lvl_nxt;
			ratio_r <= ratio_nxt;
			pend_r <= pend_nxt;
			snap_r <= snap_nxt;
			ev_r <= ev_nxt;
			note_r <= note_nxt;
			wptr_r <= wptr_nxt;
			cnt_r <= cnt_nxt;
			start_o <= so;
			trip_o <= to;
			blk_o <= bo;
			hist_r <= hist_nxt;
		end
	end

	// Record memory is not reset; the count says which entries hold data.
	always_ff @(posedge aclk) begin
		if (rec_we) mem_r[wptr_r] <= rec_d;
	end

	assign start_out = start_o;
	assign trip_out = trip_o;
	assign blocked_out = blk_o;
	assign display_note = note_r;
	assign event_out = ev_r;
endmodule // roc_stage
`default_nettype wire

// File: test/roc_far_model.sv
// Blocking source and event buffer standing at the stage's far side.
`timescale 1ns/1ps
`default_nettype none
module roc_far_model import roc_pkg::*; (
	input wire logic aclk,
	input wire logic block_req,
	input wire roc_event_t ev,
	input wire logic note,
	output logic block_in
);
	int hits[6];
	logic [31:0] stamps[6];
	int notes;
	int bad_stamp;
	logic [31:0] last_stamp;
	initial begin
		block_in = 1'h0;
		last_stamp = 32'h0000_0000;
		bad_stamp = 0;
	end
	// The block follows the request by one clock, far ahead of any operate delay.
	always @(posedge aclk) block_in <= block_req;
	always @(posedge aclk) begin
		if (ev.valid) begin
			hits[ev.code]++;
			if (ev.stamp < last_stamp) bad_stamp++;
			last_stamp <= ev.stamp;
			if (ev.code <= 3'h5) stamps[ev.code] <= ev.stamp;
		end
		if (note) notes++;
	end
	task automatic clear();
		hits = '{default: 0};
		notes = 0;
	endtask
endmodule // roc_far_model
`default_nettype wire

// File: test/roc_stage_properties.sv
// Concurrent checks on the ports of the restrained overcurrent stage.
`timescale 1ns/1ps
`default_nettype none
module roc_stage_props import roc_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic start_out,
	input wire logic trip_out,
	input wire logic blocked_out,
	input wire logic display_note,
	input wire roc_event_t event_out
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_trip_needs_start: assert property (trip_out |-> start_out)
		else $error("trip without start");
	a_block_no_start: assert property (!(blocked_out && start_out))
		else $error("start and blocked together");
	a_note_pulse: assert property (display_note |-> blocked_out ##1 !display_note)
		else $error("bad display pulse");
	a_start_holds: assert property ($rose(start_out) |=> start_out [*8])
		else $error("start changed between ticks");
	a_ev_start_on: assert property (event_out.valid && event_out.code == 3'h0 |-> start_out)
		else $error("start on event without start");
	a_ev_start_off: assert property (event_out.valid && event_out.code == 3'h1 |-> !start_out)
		else $error("start off event with start");
	a_ev_block_on: assert property (event_out.valid && event_out.code == EV_BLOCK_ON |-> blocked_out)
		else $error("block on event without blocked");
	a_ev_code_range: assert property (event_out.valid |-> event_out.code <= 3'h5)
		else $error("event code out of range");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
endmodule // roc_stage_props
bind roc_stage roc_stage_props props_u (.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out),
	.display_note(display_note), .event_out(event_out));
`default_nettype wire

// File: test/roc_stage_tb.sv
// Self-checking bench for the restrained overcurrent stage.
`timescale 1ns/1ps
`default_nettype none
module roc_stage_tb import roc_pkg::*;;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0, block_req = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, block_in, start_out, trip_out, blocked_out, note;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] rdata, rd;
	roc_meas_t meas = '{16'h0000, 16'h0000, 16'h0000, 16'h2710, 1'h1};
	roc_event_t ev;
	int mismatches = 0;
	int n_compared = 0;
	always #4 aclk = ~aclk;
	roc_stage #(.CYC_CLKS(20), .MS_CLKS(4), .DEPTH(12)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .block_in(block_in), .meas(meas), .start_out(start_out),
		.trip_out(trip_out), .blocked_out(blocked_out), .display_note(note), .event_out(ev));
	roc_far_model model_u (.aclk(aclk), .block_req(block_req), .ev(ev), .note(note), .block_in(block_in));
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			if (bvalid) break;
		end
		if (n == 200) mismatches++;
		if (n == 200) give_verdict();
		chk(32'(bresp), 32'(er));
		bready <= 1'h0;
	endtask
	task automatic rdreg(input logic [7:0] a);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
			if (rvalid) break;
		end
		if (n == 200) mismatches++;
		if (n == 200) give_verdict();
		rd = rdata;
		rs = rresp;
		rready <= 1'h0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		rdreg(a);
		chk(rd, exp);
	endtask
	task automatic wait_out(input int s, input logic v);
		int n;
		for (n = 0; n < 3000; n++) begin
			@(posedge aclk);
			if ((s == 0 ? start_out : s == 1 ? trip_out : blocked_out) === v) break;
		end
		if (n == 3000) mismatches++;
		if (n == 3000) give_verdict();
	endtask
	task automatic pick(input logic on);
		@(posedge aclk);
		meas.il1 <= on ? 16'h00f0 : 16'h0000;
	endtask
	task automatic chk_ev(input int e[6]);
		repeat (8) @(posedge aclk);
		for (int i = 0; i < 6; i++) chk(32'(model_u.hits[i]), 32'(e[i]));
		chk(32'(model_u.bad_stamp), 32'h0000_0000);
	endtask
	task automatic pulse();
		pick(1'h1);
		wait_out(0, 1'h1);
		pick(1'h0);
		wait_out(0, 1'h0);
	endtask
	task automatic t_regs();
		logic [7:0] a[6] = '{A_CTRL, A_IV1, A_IV2, A_UX1, A_UX2, A_DELAY};
		logic [31:0] e[6] = '{CTRL_RST, 32'(IV1_RST), 32'(IV2_RST), 32'(UX1_RST), 32'(UX2_RST), 32'(DELAY_RST)};
		for (int i = 0; i < 6; i++) rchk(a[i], e[i]);
		rchk(8'h60, 32'h0000_0000);
		chk(32'(rs), 32'(RESP_SLVERR));
		wr(A_STATUS, 32'h0000_0000, RESP_SLVERR);
		wr(A_DELAY, 32'h0000_0004, RESP_OKAY);
		rchk(A_DELAY, 32'h0000_0004);
	endtask
	task automatic t_trip();
		model_u.clear();
		pick(1'h1);
		wait_out(0, 1'h1);
		rchk(A_STATUS, 32'h0000_0101);
		rchk(A_EXPECT, 32'h0000_0004);
		rdreg(A_REMAIN);
		chk(32'(rd > 0 && rd <= 4), 32'h0000_0001);
		rchk(A_PICKUP, 32'h0000_0078);
		rchk(A_VOLT, 32'h0000_2710);
		rchk(A_RATIO, 32'h0000_00c8);
		wait_out(1, 1'h1);
		rchk(A_STATUS, 32'h0000_0102);
		pick(1'h0);
		wait_out(0, 1'h0);
		chk(32'(trip_out), 32'h0000_0000);
		chk_ev('{1, 1, 1, 1, 0, 0});
		rchk(A_REC_BASE + 8'h04, 32'h0000_0002);
	endtask
	task automatic t_block();
		model_u.clear();
		@(posedge aclk);
		block_req <= 1'h1;
		pick(1'h1);
		wait_out(2, 1'h1);
		chk(32'(start_out), 32'h0000_0000);
		rchk(A_STATUS, 32'h0000_0103);
		pick(1'h0);
		block_req <= 1'h0;
		wait_out(2, 1'h0);
		chk_ev('{0, 0, 0, 0, 1, 1});
		chk(32'(model_u.notes), 32'h0000_0001);
	endtask
	task automatic t_block_start();
		model_u.clear();
		pick(1'h1);
		wait_out(0, 1'h1);
		@(posedge aclk);
		block_req <= 1'h1;
		wait_out(2, 1'h1);
		chk(32'(start_out), 32'h0000_0000);
		pick(1'h0);
		block_req <= 1'h0;
		wait_out(2, 1'h0);
		chk_ev('{1, 1, 0, 0, 1, 1});
	endtask
	task automatic t_instant();
		wr(A_DELAY, 32'h0000_0000, RESP_OKAY);
		model_u.clear();
		pick(1'h1);
		wait_out(1, 1'h1);
		chk(32'(start_out), 32'h0000_0001);
		pick(1'h0);
		wait_out(1, 1'h0);
		chk_ev('{1, 1, 1, 1, 0, 0});
		chk(model_u.stamps[0], model_u.stamps[2]);
		wr(A_DELAY, 32'h0000_0004, RESP_OKAY);
	endtask
	task automatic t_select();
		wr(A_CTRL, 32'h0000_0011, RESP_OKAY);
		model_u.clear();
		pulse();
		chk_ev('{1, 0, 0, 0, 0, 0});
		wr(A_CTRL, 32'h0000_0012, RESP_OKAY);
		model_u.clear();
		pulse();
		chk_ev('{0, 1, 0, 0, 0, 0});
		wr(A_CTRL, 32'h0000_0013, RESP_OKAY);
	endtask
	task automatic t_records();
		repeat (13) pulse();
		rchk(A_REC_CNT, 32'h0000_000c);
		rchk(A_REC_BASE + 8'h04, 32'h0000_0000);
	endtask
	task automatic t_flags();
		wr(A_CTRL, 32'h0000_001b, RESP_OKAY);
		meas.u1_ok <= 1'h0;
		repeat (2) @(posedge aclk);
		rchk(A_STATUS, 32'h0000_0010);
		wr(A_CTRL, 32'h0000_0013, RESP_OKAY);
		meas.u1_ok <= 1'h1;
		rchk(A_STATUS, 32'h0000_0100);
	endtask
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		t_regs();
		t_trip();
		t_block();
		t_block_start();
		t_instant();
		t_select();
		t_records();
		t_flags();
		give_verdict();
	end
endmodule // roc_stage_tb
`default_nettype wire
